/* design/ssac_pkg.sv */
// Package: register map, field layout and serial frame of the setup bank
// ============================================================
// What this block does
// - Two-bit field picks diagnostic run style
// - Trigger source: serial command, select pulse, alert
// - Written code 3 stored as serial trigger
// - Trigger during conversion waits until it finishes
// - Triggers while one is pending or starting are dropped
// - Trigger source honoured only in capable modes
// - Three-bit field selects result word packing
// - Front-end tests run only when enabled
// - Per-axis limit checks, all off at reset
// - Unlatched alert follows live enabled sources
// - Latched alert holds until matching register read
// - Switch behaviour drives alert from axis hits
// - Flag alert enable reports any status flag
// - Done alert enable reports finished conversion set
// - One to four consecutive hits before alert
package ssac_pkg;

   // ============================================================
   // Register map (word addresses carried in the serial frame)
   localparam logic [6:0]  ADDR_SYSTEM_SETUP   = 7'h02;
   localparam logic [6:0]  ADDR_ALERT_SETUP    = 7'h03;
   localparam logic [6:0]  ADDR_RESULT_FIRST   = 7'h09;
   localparam logic [6:0]  ADDR_RESULT_LAST    = 7'h0c;
   localparam logic [6:0]  ADDR_FRONTEND_FLAGS = 7'h0d;
   localparam logic [6:0]  ADDR_SYSTEM_FLAGS   = 7'h0e;

   // ============================================================
   // Reset values and writable-bit masks
   localparam logic [15:0] SYSTEM_SETUP_RESET  = 16'h0000;
   localparam logic [15:0] ALERT_SETUP_RESET   = 16'h0000;
   localparam logic [15:0] SYSTEM_SETUP_MASK   = 16'h37e7;
   localparam logic [15:0] ALERT_SETUP_MASK    = 16'h393f;

   // ============================================================
   // Field codes
   localparam logic [1:0]  TRIG_SERIAL         = 2'h0;
   localparam logic [1:0]  TRIG_SELECT_PULSE   = 2'h1;
   localparam logic [1:0]  TRIG_ALERT_PULSE    = 2'h2;
   localparam logic [1:0]  TRIG_UNUSED         = 2'h3;
   localparam int unsigned CMD_START_BIT       = 3;
   localparam logic [2:0]  HIT_COUNT_ONE       = 3'h1;
   localparam logic [2:0]  HIT_COUNT_MAX       = 3'h4;
   localparam logic [4:0]  FRAME_LAST_BIT      = 5'h1f;
   localparam logic [12:0] REPLY_PAD           = 13'h0000;

   // ============================================================
   // System setup word
   typedef struct packed {
      logic [1:0] rsvd_15_14;
      logic [1:0] diagnostic_run_style;
      logic       rsvd_11;
      logic [1:0] trigger_source;
      logic [2:0] result_format;
      logic       frontend_test_enable;
      logic [1:0] rsvd_4_3;
      logic       z_limit_check_enable;
      logic       y_limit_check_enable;
      logic       x_limit_check_enable;
   } ssac_system_setup_s;

   // Alert setup word
   typedef struct packed {
      logic [1:0] rsvd_15_14;
      logic       latch_select;
      logic       switch_mode;
      logic       flag_alert_enable;
      logic [1:0] rsvd_10_9;
      logic       conversion_done_alert_enable;
      logic [1:0] rsvd_7_6;
      logic [1:0] threshold_hit_count;
      logic       temp_threshold_alert_enable;
      logic [2:0] axis_threshold_alert_enable;   // z, y, x
   } ssac_alert_setup_s;

   // Serial frame, most significant bit first on the wire
   typedef struct packed {
      logic       read;
      logic [6:0] addr;
      logic [15:0] data;
      logic [3:0] cmd;
      logic [3:0] check;
   } ssac_frame_s;

   // Conversion trigger sequencer
   typedef enum logic [1:0] {
      TRG_IDLE    = 2'b00,
      TRG_PENDING = 2'b01,
      TRG_START   = 2'b10
   } ssac_trig_state_e;

endpackage : ssac_pkg

/* design/ssac_spi_link.sv */
// Serial link end: frame shifter on the link clock with toggle hand-off
`timescale 1ns/100ps
module ssac_spi_link
   import ssac_pkg::*;
(
   input  wire logic        sclk,      // Link clock from host
   input  wire logic        rst_n,     // Device reset, active low
   input  wire logic        cs_n,      // Frame select, active low
   input  wire logic        mosi,      // Serial data in
   input  wire logic [31:0] reply,     // Word to send next frame
   output      logic        miso,      // Serial data out
   output      ssac_frame_s frame,     // Last complete frame
   output      logic        frame_tgl  // Toggles once per frame
);

   logic [4:0]  bit_cnt_q;
   logic [31:0] in_sh_q;
   logic [31:0] out_sh_q;
   logic        miso_q;
   ssac_frame_s frame_q;
   logic        tgl_q;
   wire         first_bit = (bit_cnt_q == 5'h00);
   wire         last_bit  = (bit_cnt_q == FRAME_LAST_BIT);
   wire  [31:0] word_in   = {in_sh_q[30:0], mosi};

   // ============================================================
   // Bit counter; deselect clears it since sclk may stop between frames
   always_ff @(posedge sclk or posedge cs_n or negedge rst_n) begin
      if (!rst_n)
         bit_cnt_q <= 5'h00;
      else if (cs_n)
         bit_cnt_q <= 5'h00;
      else
         bit_cnt_q <= bit_cnt_q + 5'h01;
   end

   // Shifters; reply is quiet by the time a new frame starts
   always_ff @(posedge sclk or negedge rst_n) begin
      if (!rst_n) begin
         in_sh_q  <= 32'h0000_0000;
         out_sh_q <= 32'h0000_0000;
         miso_q   <= 1'b0;
      end else begin
         in_sh_q  <= word_in;
         out_sh_q <= first_bit ? {reply[30:0], 1'b0}
                               : {out_sh_q[30:0], 1'b0};
         miso_q   <= first_bit ? reply[31] : out_sh_q[31];
      end
   end

   // Frame word is held for a whole frame after the toggle flips
   always_ff @(posedge sclk or negedge rst_n) begin
      if (!rst_n) begin
         frame_q <= '0;
         tgl_q   <= 1'b0;
      end else if (last_bit) begin
         frame_q <= ssac_frame_s'(word_in);
         tgl_q   <= ~tgl_q;
      end
   end

   assign miso      = miso_q;
   assign frame     = frame_q;
   assign frame_tgl = tgl_q;

endmodule : ssac_spi_link

/* design/ssac_top.sv */
// Setup bank top: registers, conversion trigger and alert pin logic
`timescale 1ns/100ps
module ssac_top
   import ssac_pkg::*;
(
   input  wire logic       clk,                  // Device clock, 40 MHz
   input  wire logic       rst_n,                // Async reset, active low
   input  wire logic       sclk,                 // Serial link clock
   input  wire logic       cs_n,                 // Frame select pin
   input  wire logic       mosi,                 // Serial data in
   output      logic       miso,                 // Serial data out
   input  wire logic       alert_in,             // Alert pin level
   output      logic       alert_out,            // Alert pin drive value
   output      logic       alert_oe_n,           // Low drives alert pin
   input  wire logic       op_mode_trig_capable, // Mode accepts triggers
   input  wire logic       conv_busy,            // Conversion running
   input  wire logic       conv_done,            // Conversion set done
   input  wire logic [2:0] axis_beyond,          // Z,Y,X beyond threshold
   input  wire logic [15:0] frontend_flags,      // Front-end status flags
   input  wire logic [15:0] system_flags,        // System status flags
   input  wire logic       frontend_test_req,    // Front-end test request
   output      logic       conv_start,           // Start one conversion
   output      logic       frontend_test_go,     // Front-end test allowed
   output      logic [1:0] diagnostic_run_style, // Diagnostic style
   output      logic [2:0] result_format,        // Result packing
   output      logic [2:0] limit_check_enable,   // Z,Y,X limit checks
   output      logic [1:0] threshold_hit_count   // Hits needed minus one
);

   // ============================================================
   // Write cleanup and address range helpers
   function automatic ssac_system_setup_s clean_system(
      input logic [15:0] wr);
      ssac_system_setup_s v;
      v = ssac_system_setup_s'(wr & SYSTEM_SETUP_MASK);
      if (v.trigger_source == TRIG_UNUSED)
         v.trigger_source = TRIG_SERIAL;
      return v;
   endfunction : clean_system

   function automatic logic in_range(
      input logic [6:0] a,
      input logic [6:0] lo,
      input logic [6:0] hi);
      return (a >= lo) && (a <= hi);
   endfunction : in_range

   // ============================================================
   // Link side and frame hand-off
   ssac_frame_s frame_link;
   logic        frame_tgl_link;
   logic [31:0] reply_q;

   ssac_spi_link u_link (
      .sclk      (sclk),
      .rst_n     (rst_n),
      .cs_n      (cs_n),
      .mosi      (mosi),
      .reply     (reply_q),
      .miso      (miso),
      .frame     (frame_link),
      .frame_tgl (frame_tgl_link)
   );

   // Toggle and pin synchronisers; stage one feeds stage two only
   logic [2:0] tgl_sync_q;
   logic [2:0] cs_sync_q;
   logic [2:0] alert_sync_q;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         tgl_sync_q   <= 3'h0;
         cs_sync_q    <= 3'h7;
         alert_sync_q <= 3'h7;
      end else begin
         tgl_sync_q   <= {tgl_sync_q[1:0], frame_tgl_link};
         cs_sync_q    <= {cs_sync_q[1:0], cs_n};
         alert_sync_q <= {alert_sync_q[1:0], alert_in};
      end
   end

   wire frame_seen  = tgl_sync_q[2] ^ tgl_sync_q[1];
   wire cs_rise     = cs_sync_q[1] & ~cs_sync_q[2];
   wire alert_fall  = ~alert_sync_q[1] & alert_sync_q[2];

   // Frame word is stable for a full frame after its toggle, so a
   // single capture on the synchronised edge is safe
   ssac_frame_s frame_q;
   logic        frame_vld_q;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         frame_q     <= '0;
         frame_vld_q <= 1'b0;
      end else begin
         frame_vld_q <= frame_seen;
         if (frame_seen)
            frame_q <= frame_link;
      end
   end

   // ============================================================
   // Register decode
   wire wr_system  = frame_vld_q & ~frame_q.read &
                     (frame_q.addr == ADDR_SYSTEM_SETUP);
   wire wr_alert   = frame_vld_q & ~frame_q.read &
                     (frame_q.addr == ADDR_ALERT_SETUP);
   wire rd_result  = frame_vld_q & frame_q.read &
                     in_range(frame_q.addr, ADDR_RESULT_FIRST,
                              ADDR_RESULT_LAST);
   wire rd_flags   = frame_vld_q & frame_q.read &
                     in_range(frame_q.addr, ADDR_FRONTEND_FLAGS,
                              ADDR_SYSTEM_FLAGS);
   wire serial_cmd = frame_vld_q & frame_q.cmd[CMD_START_BIT];

   ssac_system_setup_s sys_q;
   ssac_alert_setup_s  alr_q;

   // Setup registers; reserved bits are masked off on every write
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sys_q <= ssac_system_setup_s'(SYSTEM_SETUP_RESET);
         alr_q <= ssac_alert_setup_s'(ALERT_SETUP_RESET);
      end else begin
         if (wr_system)
            sys_q <= clean_system(frame_q.data);
         if (wr_alert)
            alr_q <= ssac_alert_setup_s'(frame_q.data &
                                         ALERT_SETUP_MASK);
      end
   end

   // Read data; unmapped words and result words read as zero here
   logic [15:0] rdata_d;
   always_comb begin
      rdata_d = 16'h0000;
      unique case (frame_q.addr)
         ADDR_SYSTEM_SETUP:   rdata_d = sys_q;
         ADDR_ALERT_SETUP:    rdata_d = alr_q;
         ADDR_FRONTEND_FLAGS: rdata_d = frontend_flags;
         ADDR_SYSTEM_FLAGS:   rdata_d = system_flags;
         default:             rdata_d = 16'h0000;
      endcase
   end

   // ============================================================
   // Conversion trigger sequencer
   wire swm        = alr_q.switch_mode;
   wire src_serial = (sys_q.trigger_source == TRIG_SERIAL) & serial_cmd;
   wire src_select = (sys_q.trigger_source == TRIG_SELECT_PULSE) &
                     cs_rise;
   wire src_alert  = (sys_q.trigger_source == TRIG_ALERT_PULSE) &
                     alert_fall & ~swm;
   wire trig_evt   = op_mode_trig_capable &
                     (src_serial | src_select | src_alert);

   ssac_trig_state_e trg_q;
   ssac_trig_state_e trg_d;
   logic             conv_start_q;

   // Busy defers the start; anything in between is dropped
   always_comb begin
      trg_d = trg_q;
      unique case (trg_q)
         TRG_IDLE:
            if (trig_evt)
               trg_d = conv_busy ? TRG_PENDING : TRG_START;
         TRG_PENDING:
            if (!conv_busy)
               trg_d = TRG_START;
         TRG_START:
            trg_d = TRG_IDLE;
         default:
            trg_d = TRG_IDLE;
      endcase
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         trg_q        <= TRG_IDLE;
         conv_start_q <= 1'b0;
      end else begin
         trg_q        <= trg_d;
         conv_start_q <= (trg_d == TRG_START);
      end
   end

   // ============================================================
   // Consecutive threshold hit counters, one per axis
   wire [2:0] lim_en = {sys_q.z_limit_check_enable,
                        sys_q.y_limit_check_enable,
                        sys_q.x_limit_check_enable};
   wire [2:0] hits_needed = {1'b0, alr_q.threshold_hit_count} +
                            HIT_COUNT_ONE;
   logic [2:0] hit_cnt_q [3];
   logic [2:0] axis_hit;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         for (int i = 0; i < 3; i++)
            hit_cnt_q[i] <= 3'h0;
      end else if (conv_done) begin
         for (int i = 0; i < 3; i++)
            if (axis_beyond[i] & lim_en[i])
               hit_cnt_q[i] <= (hit_cnt_q[i] == HIT_COUNT_MAX) ?
                               HIT_COUNT_MAX : hit_cnt_q[i] + 3'h1;
            else
               hit_cnt_q[i] <= 3'h0;
      end
   end

   always_comb begin
      for (int i = 0; i < 3; i++)
         axis_hit[i] = (hit_cnt_q[i] >= hits_needed);
   end

   // ============================================================
   // Alert sources, live and latched
   wire thr_live  = |(axis_hit & lim_en &
                      alr_q.axis_threshold_alert_enable);
   wire flag_live = alr_q.flag_alert_enable &
                    (|frontend_flags | |system_flags);
   wire done_live = alr_q.conversion_done_alert_enable &
                    conv_done;

   logic thr_lat_q;
   logic flag_lat_q;
   logic done_lat_q;

   // A new event in the clearing read's cycle keeps its latch set
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         thr_lat_q  <= 1'b0;
         flag_lat_q <= 1'b0;
         done_lat_q <= 1'b0;
      end else begin
         thr_lat_q  <= thr_live  | (thr_lat_q  & ~rd_result);
         flag_lat_q <= flag_live | (flag_lat_q & ~rd_flags);
         done_lat_q <= done_live | (done_lat_q & ~rd_result);
      end
   end

   wire irq_live  = thr_live | flag_live | done_live;
   wire irq_held  = thr_lat_q | flag_lat_q | done_lat_q;
   wire alert_irq = alr_q.latch_select ? irq_held : irq_live;
   // Switch behaviour ignores the latch and the flag and done sources
   wire alert_d   = swm ? thr_live : alert_irq;
   // The pin is released while it serves as the trigger input
   wire pin_in_use = ~swm &
                     (sys_q.trigger_source == TRIG_ALERT_PULSE);

   logic alert_oe_n_q;
   logic test_go_q;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         alert_oe_n_q <= 1'b1;
         test_go_q    <= 1'b0;
         reply_q      <= 32'h0000_0000;
      end else begin
         alert_oe_n_q <= ~(alert_d & ~pin_in_use);
         test_go_q    <= frontend_test_req &
                         sys_q.frontend_test_enable;
         if (frame_vld_q)
            reply_q <= {rdata_d, REPLY_PAD, alert_d,
                        (trg_q == TRG_PENDING), conv_busy};
      end
   end

   // ============================================================
   // Outputs straight from flip-flops, except alert_out tied low
   assign alert_out            = 1'b0;  // Open drain: only pulls low
   assign alert_oe_n           = alert_oe_n_q;
   assign conv_start           = conv_start_q;
   assign frontend_test_go     = test_go_q;
   assign diagnostic_run_style = sys_q.diagnostic_run_style;
   assign result_format        = sys_q.result_format;
   assign limit_check_enable   = lim_en;
   assign threshold_hit_count  = alr_q.threshold_hit_count;

endmodule : ssac_top

/* tb/ssac_host_model.sv */
// Host controller model: drives serial frames and collects replies
`timescale 1ns/100ps
module ssac_host_model
   import ssac_pkg::*;
(
   output logic       sclk,  // Link clock, still between frames
   output logic       cs_n,  // Frame select, active low
   output logic       mosi,  // Serial data to device
   input  wire logic  miso   // Serial data from device
);
   logic [31:0] rx;   // Reply captured in the last frame

   // ============================================================
   // Idle lines: clock low, no device selected
   initial begin
      sclk = 1'b0;
      cs_n = 1'b1;
      mosi = 1'b0;
      rx   = 32'h0;
   end

   // One 32-bit frame, MSB first; data set half a period before each rise
   task automatic xfer(input ssac_frame_s f);
      logic [31:0] tx;
      tx   = f;
      #7;
      cs_n = 1'b0;
      for (int i = 31; i >= 0; i--) begin
         mosi = tx[i];
         #24 sclk = 1'b1;
         #24 sclk = 1'b0;
         rx[i] = miso;   // Device shifts after the rise, stable here
      end
      #24 cs_n = 1'b1;
      mosi = ~mosi;      // Released line must not keep the last bit
      #300;              // Gap well beyond the 8 clk spacing
   endtask : xfer
endmodule : ssac_host_model

/* tb/ssac_top_assertions.sv */
// Checker for the setup bank top: trigger, alert and field timing
`timescale 1ns/100ps
module ssac_top_assertions
   import ssac_pkg::*;
(
   input wire logic        clk,                  // Device clock
   input wire logic        rst_n,                // Async reset
   input wire logic        cs_n,                 // Frame select
   input wire logic        alert_out,            // Alert drive value
   input wire logic        alert_oe_n,           // Alert pin enable
   input wire logic        conv_busy,            // Conversion running
   input wire logic        conv_done,            // Conversion set done
   input wire logic [15:0] frontend_flags,       // Front-end flags
   input wire logic [15:0] system_flags,         // System flags
   input wire logic        frontend_test_req,    // Test request
   input wire logic        conv_start,           // Start pulse
   input wire logic        frontend_test_go,     // Test allowed
   input wire logic [1:0]  diagnostic_run_style, // Diagnostic style
   input wire logic [2:0]  result_format,        // Result packing
   input wire logic [2:0]  limit_check_enable,   // Limit checks
   input wire logic [1:0]  threshold_hit_count   // Hit count field
);
   logic [3:0] since_cs_q, since_cs_d;   // Clk cycles since frame end
   logic [3:0] cause_q;                  // Recent alert causes
   logic       cause_w;

   // ============================================================
   // Helper history; config changes and alert causes both need slack
   assign cause_w    = conv_done | (|frontend_flags) | (|system_flags);
   assign since_cs_d = !cs_n ? 4'h0 :
                       (since_cs_q == 4'hf) ? since_cs_q : since_cs_q + 4'h1;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         since_cs_q <= 4'hf;
         cause_q    <= 4'h0;
      end else begin
         since_cs_q <= since_cs_d;
         cause_q    <= {cause_q[2:0], cause_w};
      end
   end

   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);

   sequence s_start_pulse;
      conv_start ##1 !conv_start;
   endsequence

   // ============================================================
   // Assertions
   chk_reset_fields: assert property ($rose(rst_n) |->
      {diagnostic_run_style, result_format, limit_check_enable} == 8'h00)
      else $error("fields not cleared by reset");
   chk_fields_frame: assert property (!$stable({diagnostic_run_style,
      result_format, limit_check_enable, threshold_hit_count})
      |-> since_cs_q < 4'hc) else $error("field changed without frame");
   chk_start_single: assert property (conv_start |-> s_start_pulse)
      else $error("start pulse longer than one cycle");
   chk_start_after_busy: assert property (conv_start |->
      !$past(conv_busy)) else $error("start while conversion ran");
   chk_no_start_busy: assert property (conv_busy |-> !conv_start)
      else $error("start during busy");
   chk_test_gate: assert property (frontend_test_go |->
      $past(frontend_test_req)) else $error("test allowed without request");
   chk_drive_value: assert property (alert_out == 1'b0)
      else $error("alert drive value not low");
   chk_alert_cause: assert property ($fell(alert_oe_n) |->
      (|cause_q) || since_cs_q < 4'hc) else $error("alert without cause");
endmodule : ssac_top_assertions

bind ssac_top ssac_top_assertions chk_u (
   .clk(clk), .rst_n(rst_n), .cs_n(cs_n), .alert_out(alert_out),
   .alert_oe_n(alert_oe_n), .conv_busy(conv_busy), .conv_done(conv_done),
   .frontend_flags(frontend_flags), .system_flags(system_flags),
   .frontend_test_req(frontend_test_req), .conv_start(conv_start),
   .frontend_test_go(frontend_test_go),
   .diagnostic_run_style(diagnostic_run_style),
   .result_format(result_format), .limit_check_enable(limit_check_enable),
   .threshold_hit_count(threshold_hit_count));

/* tb/testbench.sv */
// Self-checking bench for the setup bank top with host model
`timescale 1ns/100ps
module testbench
   import ssac_pkg::*;
;
   `define CHK(a, b, m) begin total_checks++; if ((a) !== (b)) begin \
      fails++; $display("wrong value at %0t: %s", $time, m); end end
   logic        clk, rst_n, alert_low, op_cap, conv_busy, conv_done, ftreq;
   logic [2:0]  axis, fmt, lim;
   logic [1:0]  drs, hit;
   logic [15:0] fe_flags, sys_flags, w, d, e, seed;
   wire         sclk, cs_n, mosi, miso, alert_out, alert_oe_n;
   wire         conv_start, ft_go, alert_in;
   int          fails, total_checks, starts, base, left, seen;
   ssac_frame_s cmd_f;

   // Pulled-up open-drain alert wire; the bench may pull it low too
   assign alert_in = !(!alert_oe_n || alert_low);
   always #12.5 clk = ~clk;

   ssac_host_model host (.sclk(sclk), .cs_n(cs_n), .mosi(mosi), .miso(miso));
   ssac_top dut_u (.clk(clk), .rst_n(rst_n), .sclk(sclk), .cs_n(cs_n),
      .mosi(mosi), .miso(miso), .alert_in(alert_in), .alert_out(alert_out),
      .alert_oe_n(alert_oe_n), .op_mode_trig_capable(op_cap),
      .conv_busy(conv_busy), .conv_done(conv_done), .axis_beyond(axis),
      .frontend_flags(fe_flags), .system_flags(sys_flags),
      .frontend_test_req(ftreq), .conv_start(conv_start),
      .frontend_test_go(ft_go), .diagnostic_run_style(drs),
      .result_format(fmt), .limit_check_enable(lim),
      .threshold_hit_count(hit));

   // ============================================================
   // Conversion datapath stand-in: busy the cycle after start, 201 clk
   always @(negedge clk) begin
      conv_done <= 1'b0;
      seen      <= conv_start;
      if (seen) begin
         starts++;
         conv_busy <= 1'b1;
         left      <= 200;
      end else if (conv_busy && left == 0) begin
         conv_busy <= 1'b0;
         conv_done <= 1'b1;
      end else if (conv_busy) begin
         left <= left - 1;
      end
   end

   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction : lfsr

   // Expected system word: reserved bits dropped, unused trigger code 3
   function automatic logic [15:0] exp_sys(input logic [15:0] v);
      logic [15:0] r;
      r = v & SYSTEM_SETUP_MASK;
      if (r[10:9] == TRIG_UNUSED) r[10:9] = TRIG_SERIAL;
      return r;
   endfunction : exp_sys

   task automatic wr(input logic [6:0] a, input logic [15:0] v);
      host.xfer('{1'b0, a, v, 4'h0, 4'h0});
      settle(1);
   endtask : wr

   // Reply of a frame arrives in the following frame
   task automatic rd(input logic [6:0] a, output logic [15:0] v);
      host.xfer('{1'b1, a, 16'h0, 4'h0, 4'h0});
      host.xfer('{1'b1, a, 16'h0, 4'h0, 4'h0});
      v = host.rx[31:16];
      settle(1);
   endtask : rd

   task automatic settle(input int n);
      repeat (n) @(negedge clk);
   endtask : settle

   task automatic conv_once();
      host.xfer(cmd_f);
      settle(400);
   endtask : conv_once

   task automatic complete_run();
      if (fails == 0 && total_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : complete_run

   // Hang guard, far beyond the expected run of some 12000 cycles
   initial begin
      #2_000_000;
      fails++;
      complete_run();
   end

   // ============================================================
   // Main sequence
   initial begin
      clk = 1'b0; rst_n = 1'b0; alert_low = 1'b0; op_cap = 1'b1;
      conv_busy = 1'b0; conv_done = 1'b0; ftreq = 1'b0; axis = 3'h0;
      fe_flags = 16'h0; sys_flags = 16'h0; seed = 16'h0055;
      fails = 0; total_checks = 0; starts = 0; left = 0;
      cmd_f = '{1'b1, ADDR_SYSTEM_SETUP, 16'h0, 4'h8, 4'h0};
      settle(12);
      rst_n = 1'b1;
      settle(10);
      rd(ADDR_SYSTEM_SETUP, d); `CHK(d, SYSTEM_SETUP_RESET, "sys reset")
      rd(ADDR_ALERT_SETUP, d); `CHK(d, ALERT_SETUP_RESET, "alert reset")
      `CHK({drs, fmt, lim}, 8'h00, "fields reset")
      // All codes of the style, trigger and format fields first, then random words
      for (int i = 0; i < 12; i++) begin
         w = (i < 8) ? {2'h3, 2'(i), 1'b1, 2'(i), 3'(i), 6'h3f} : seed;
         seed = lfsr(seed);
         wr(ADDR_SYSTEM_SETUP, w);
         e = exp_sys(w);
         rd(ADDR_SYSTEM_SETUP, d);
         `CHK(d, e, "sys readback")
         `CHK({drs, fmt, lim}, {e[13:12], e[8:6], e[2:0]}, "fields")
      end
      for (int i = 0; i < 4; i++) begin
         w = (i == 0) ? 16'hffff : seed;
         seed = lfsr(seed);
         wr(ADDR_ALERT_SETUP, w);
         rd(ADDR_ALERT_SETUP, d);
         `CHK(d, w & ALERT_SETUP_MASK, "alert readback")
         `CHK(hit, w[5:4], "hit count field")
      end
      wr(ADDR_ALERT_SETUP, 16'h0);
      wr(ADDR_SYSTEM_SETUP, 16'h0);
      wr(7'h05, 16'hffff);
      rd(ADDR_SYSTEM_SETUP, d); `CHK(d, 16'h0, "unmapped write")
      // Front-end test gate
      ftreq = 1'b1;
      settle(3); `CHK(ft_go, 1'b0, "test gate closed")
      wr(ADDR_SYSTEM_SETUP, 16'h0020);
      settle(3); `CHK(ft_go, 1'b1, "test gate open")
      ftreq = 1'b0;
      wr(ADDR_SYSTEM_SETUP, 16'h0);
      // Triggers: serial, redundant during busy, incapable mode
      settle(400); base = starts;
      conv_once(); `CHK(starts - base, 1, "serial start")
      base = starts;
      host.xfer(cmd_f); host.xfer(cmd_f); host.xfer(cmd_f);
      settle(700); `CHK(starts - base, 2, "queued start")
      op_cap = 1'b0; base = starts;
      conv_once(); `CHK(starts - base, 0, "mode gate")
      op_cap = 1'b1;
      wr(ADDR_SYSTEM_SETUP, 16'h0200);
      settle(400); base = starts;
      rd(ADDR_SYSTEM_SETUP, d);
      settle(700); `CHK(starts - base, 2, "select pulse")
      wr(ADDR_SYSTEM_SETUP, 16'h0400);
      settle(400); base = starts;
      alert_low = 1'b1; settle(4); alert_low = 1'b0;
      settle(400); `CHK(starts - base, 1, "alert pulse")
      wr(ADDR_SYSTEM_SETUP, 16'h0);
      // Alert: live flag, latched flag, latched done
      wr(ADDR_ALERT_SETUP, 16'h0800);
      sys_flags = 16'h0010;
      settle(5); `CHK(alert_oe_n, 1'b0, "flag alert")
      sys_flags = 16'h0;
      settle(5); `CHK(alert_oe_n, 1'b1, "live release")
      wr(ADDR_ALERT_SETUP, 16'h2800);
      fe_flags = 16'h0001; settle(5); fe_flags = 16'h0;
      settle(10); `CHK(alert_oe_n, 1'b0, "flag latched")
      rd(ADDR_FRONTEND_FLAGS, d);
      settle(8); `CHK(alert_oe_n, 1'b1, "flag cleared")
      wr(ADDR_ALERT_SETUP, 16'h2100);
      conv_once(); `CHK(alert_oe_n, 1'b0, "done latched")
      rd(ADDR_RESULT_FIRST, d);
      settle(8); `CHK(alert_oe_n, 1'b1, "done cleared")
      // Switch mode on x, two hits needed; limit check enabled first
      wr(ADDR_SYSTEM_SETUP, 16'h0001);
      wr(ADDR_ALERT_SETUP, 16'h1011);
      axis = 3'b001;
      conv_once(); `CHK(alert_oe_n, 1'b1, "one hit")
      conv_once(); `CHK(alert_oe_n, 1'b0, "two hits")
      axis = 3'b000;
      conv_once(); `CHK(alert_oe_n, 1'b1, "switch off")
      complete_run();
   end
endmodule : testbench
